// ---- rtl/presettable_down_counter.sv ----
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
// Function
// - with gate low and no load or clear, each clock edge decrements by one
// - with gate high and no load or clear, the count holds
// - zero flag low while count is zero and gate low, one clock period
// - synchronous load low captures preset bus on next edge, gate ignored
// - asynchronous load low forces preset bus into count at once
// - clear low forces maximum count at once: 99 decimal, 255 binary
// - priority: clear, asynchronous load, synchronous load, count gate
// - counting from zero reloads maximum, giving 100 or 256 clock cycle
// - all controls and the zero flag are active low
// - decimal variant is two BCD digits, binary variant one 8-bit counter
// - preset upper nibble is tens digit, lower is units; binary bit 7 MSB
module presettable_down_counter import down_counter_pkg::*; (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_count_gate_n,
   input wire logic i_load_sync_n,
   input wire logic i_load_async_n,
   input wire logic i_set_max_n,
   input wire logic [COUNT_W-1:0] i_preset_bus_bits,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [APB_AW-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   output logic o_zero_flag_n
);
   reg_link_if link ();

   typedef enum logic [2:0] {
      ACT_HOLD,
      ACT_COUNT,
      ACT_LOAD_SYNC,
      ACT_LOAD_ASYNC,
      ACT_SET_MAX
   } action_e;

   typedef enum logic {
      MODE_BINARY,
      MODE_DECIMAL
   } mode_e;

   action_e action;
   mode_e mode;
   logic [DIGIT_W-1:0] units;
   logic [DIGIT_W-1:0] tens;
   logic [DIGIT_W-1:0] next_units;
   logic [DIGIT_W-1:0] next_tens;
   logic [DIGIT_W-1:0] live_units;
   logic [DIGIT_W-1:0] live_tens;
   logic [DIGIT_W-1:0] preset_units;
   logic [DIGIT_W-1:0] preset_tens;
   logic [DIGIT_W-1:0] max_units;
   logic [DIGIT_W-1:0] max_tens;
   logic [DIGIT_W-1:0] step_units;
   logic [DIGIT_W-1:0] step_tens;
   logic [COUNT_W-1:0] live_count;
   logic units_borrow;
   logic live_units_zero;
   logic live_tens_zero;
   logic gate_on;
   logic count_is_zero;

   // maximum count of the selected variant
   function automatic logic [COUNT_W-1:0] max_count(
      input mode_e sel
   );
      case (sel)
         MODE_DECIMAL: begin
            max_count = MAX_DECIMAL;
         end
         MODE_BINARY: begin
            max_count = MAX_BINARY;
         end
         default: begin
            max_count = MAX_BINARY;
         end
      endcase
   endfunction : max_count

   // top value of one digit: nine for a decade, fifteen for a binary nibble
   function automatic logic [DIGIT_W-1:0] digit_top(
      input mode_e sel
   );
      case (sel)
         MODE_DECIMAL: begin
            digit_top = DIGIT_MAX;
         end
         MODE_BINARY: begin
            digit_top = MAX_BINARY[DIGIT_W-1:0];
         end
         default: begin
            digit_top = MAX_BINARY[DIGIT_W-1:0];
         end
      endcase
   endfunction : digit_top

   function automatic logic digit_is_zero(
      input logic [DIGIT_W-1:0] digit
   );
      digit_is_zero = (digit == '0);
   endfunction : digit_is_zero

   // one digit down; zero wraps to the top value, the caller passes the borrow on
   function automatic logic [DIGIT_W-1:0] digit_down(
      input logic [DIGIT_W-1:0] digit,
      input mode_e sel
   );
      if (digit_is_zero(digit)) begin
         digit_down = digit_top(sel);
      end else begin
         digit_down = digit - DIGIT_ONE;
      end
   endfunction : digit_down

   // upper nibble is the tens digit, lower nibble the units, msb first in each
   function automatic logic [DIGIT_W-1:0] upper_digit(
      input logic [COUNT_W-1:0] value
   );
      upper_digit = value[COUNT_W-1:DIGIT_W];
   endfunction : upper_digit

   function automatic logic [DIGIT_W-1:0] lower_digit(
      input logic [COUNT_W-1:0] value
   );
      lower_digit = value[DIGIT_W-1:0];
   endfunction : lower_digit

   // one decision per clock for both digits, highest priority first
   function automatic action_e pick_action(
      input logic set_max_n,
      input logic load_async_n,
      input logic load_sync_n,
      input logic gate_n
   );
      if (!set_max_n) begin
         pick_action = ACT_SET_MAX;
      end else if (!load_async_n) begin
         pick_action = ACT_LOAD_ASYNC;
      end else if (!load_sync_n) begin
         pick_action = ACT_LOAD_SYNC;
      end else if (!gate_n) begin
         pick_action = ACT_COUNT;
      end else begin
         pick_action = ACT_HOLD;
      end
   endfunction : pick_action

   assign mode = mode_e'(link.decimal_mode);
   assign action = pick_action(i_set_max_n, i_load_async_n, i_load_sync_n, i_count_gate_n);
   assign gate_on = ~i_count_gate_n;
   assign preset_units = lower_digit(i_preset_bus_bits);
   assign preset_tens = upper_digit(i_preset_bus_bits);
   assign max_units = lower_digit(max_count(mode));
   assign max_tens = upper_digit(max_count(mode));
   assign step_units = digit_down(units, mode);
   assign step_tens = digit_down(tens, mode);
   // the tens digit moves only when the units digit passes through zero
   assign units_borrow = digit_is_zero(units);

   // clear and asynchronous load reach the visible count without a clock;
   // the digit flops catch up on the next edge, so only i_rstn feeds a reset path
   always_comb begin
      case (action)
         ACT_SET_MAX: begin
            live_units = max_units;
         end
         ACT_LOAD_ASYNC: begin
            live_units = preset_units;
         end
         ACT_LOAD_SYNC: begin
            live_units = units;
         end
         ACT_COUNT: begin
            live_units = units;
         end
         ACT_HOLD: begin
            live_units = units;
         end
         default: begin
            live_units = units;
         end
      endcase
   end

   always_comb begin
      case (action)
         ACT_SET_MAX: begin
            live_tens = max_tens;
         end
         ACT_LOAD_ASYNC: begin
            live_tens = preset_tens;
         end
         ACT_LOAD_SYNC: begin
            live_tens = tens;
         end
         ACT_COUNT: begin
            live_tens = tens;
         end
         ACT_HOLD: begin
            live_tens = tens;
         end
         default: begin
            live_tens = tens;
         end
      endcase
   end

   always_comb begin
      case (action)
         ACT_SET_MAX: begin
            next_units = max_units;
         end
         ACT_LOAD_ASYNC: begin
            next_units = preset_units;
         end
         ACT_LOAD_SYNC: begin
            next_units = preset_units;
         end
         ACT_COUNT: begin
            next_units = step_units;
         end
         ACT_HOLD: begin
            next_units = units;
         end
         default: begin
            next_units = units;
         end
      endcase
   end

   always_comb begin
      case (action)
         ACT_SET_MAX: begin
            next_tens = max_tens;
         end
         ACT_LOAD_ASYNC: begin
            next_tens = preset_tens;
         end
         ACT_LOAD_SYNC: begin
            next_tens = preset_tens;
         end
         ACT_COUNT: begin
            if (units_borrow) begin
               next_tens = step_tens;
            end else begin
               next_tens = tens;
            end
         end
         ACT_HOLD: begin
            next_tens = tens;
         end
         default: begin
            next_tens = tens;
         end
      endcase
   end

   // units digit; in binary mode it is the low nibble of one 8-bit counter
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         units <= MAX_BINARY[DIGIT_W-1:0];
      end else begin
         units <= next_units;
      end
   end

   // tens digit; in binary mode it is the high nibble of the same counter
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tens <= MAX_BINARY[COUNT_W-1:DIGIT_W];
      end else begin
         tens <= next_tens;
      end
   end

   assign live_count = {live_tens, live_units};
   assign live_units_zero = digit_is_zero(live_units);
   assign live_tens_zero = digit_is_zero(live_tens);
   // left combinational so a cascade gate reaches the flag within the cycle
   assign count_is_zero = live_units_zero & live_tens_zero;
   assign o_zero_flag_n = ~(count_is_zero & gate_on);

   assign link.count = live_count;
   assign link.zero_active = ~o_zero_flag_n;

   counter_apb_regs u_counter_apb_regs (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_psel(i_psel),
      .i_penable(i_penable),
      .i_pwrite(i_pwrite),
      .i_paddr(i_paddr),
      .i_pwdata(i_pwdata),
      .o_pready(o_pready),
      .o_prdata(o_prdata),
      .o_pslverr(o_pslverr),
      .link(link)
   );
endmodule : presettable_down_counter

// ---- rtl/down_counter_pkg.sv ----
package down_counter_pkg;
   localparam int COUNT_W = 8;
   localparam int DIGIT_W = 4;
   localparam int APB_AW = 12;
   localparam logic [APB_AW-1:0] CTRL_OFFSET = 12'h000;
   localparam logic [APB_AW-1:0] STATUS_OFFSET = 12'h004;
   localparam int CTRL_DECIMAL_BIT = 0;
   localparam int STATUS_ZERO_BIT = 8;
   localparam logic CTRL_DECIMAL_RESET = 1'b0;
   localparam logic [COUNT_W-1:0] MAX_BINARY = 8'hFF;
   localparam logic [COUNT_W-1:0] MAX_DECIMAL = 8'h99;
   localparam logic [DIGIT_W-1:0] DIGIT_MAX = 4'h9;
   localparam logic [DIGIT_W-1:0] DIGIT_ONE = 4'h1;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 8'h01;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 8'h00;
   localparam logic [31:0] RDATA_ZERO = 32'h00000000;
endpackage : down_counter_pkg

// ---- rtl/reg_link_if.sv ----
`timescale 1ns/1ps
interface reg_link_if;
   logic decimal_mode;
   logic [7:0] count;
   logic zero_active;
   modport regs (output decimal_mode, input count, input zero_active);
   modport core (input decimal_mode, output count, output zero_active);
endinterface : reg_link_if

// ---- rtl/counter_apb_regs.sv ----
`timescale 1ns/1ps
module counter_apb_regs import down_counter_pkg::*; (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [APB_AW-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   reg_link_if.regs link
);
   logic decimal_mode;
   logic access;
   logic hit_ctrl;
   logic hit_status;

   assign access = i_psel & i_penable;
   assign hit_ctrl = (i_paddr == CTRL_OFFSET);
   assign hit_status = (i_paddr == STATUS_OFFSET);
   assign link.decimal_mode = decimal_mode;

   // one wait state so that pready and prdata both leave flip-flops
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= RDATA_ZERO;
      end else begin
         o_pready <= access & ~o_pready;
         o_pslverr <= access & ~o_pready & ~(hit_ctrl | hit_status);
         o_prdata <= RDATA_ZERO;
         if (access && !o_pready && !i_pwrite) begin
            if (hit_ctrl) begin
               o_prdata[CTRL_DECIMAL_BIT] <= decimal_mode;
            end else if (hit_status) begin
               o_prdata[COUNT_W-1:0] <= link.count;
               o_prdata[STATUS_ZERO_BIT] <= link.zero_active;
            end
         end
      end
   end

   // write lands only on the edge where the master sees pready
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         decimal_mode <= CTRL_DECIMAL_RESET;
      end else if (access && o_pready && i_pwrite && hit_ctrl) begin
         decimal_mode <= i_pwdata[CTRL_DECIMAL_BIT];
      end
   end
endmodule : counter_apb_regs

// ---- tb/pdc_sva.sv ----
`timescale 1ns/1ps
module pdc_sva import down_counter_pkg::*; (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_count_gate_n,
   input wire logic i_load_sync_n,
   input wire logic i_load_async_n,
   input wire logic i_set_max_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [COUNT_W-1:0] i_preset_bus_bits,
   input wire logic [APB_AW-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_zero_flag_n
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   wire quiet = i_set_max_n & i_load_async_n;
   chk_flag_needs_gate: assert property (!o_zero_flag_n |-> !i_count_gate_n)
      else $error("zero flag low with gate high");
   chk_clear_wins: assert property (!i_set_max_n |-> o_zero_flag_n)
      else $error("zero flag low during clear");
   chk_async_load: assert property (i_set_max_n && !i_load_async_n && !i_count_gate_n
      |-> o_zero_flag_n == (i_preset_bus_bits != 8'h00)) else $error("async load flag wrong");
   chk_zero_reload: assert property (quiet && i_load_sync_n && !o_zero_flag_n
      ##1 quiet |-> o_zero_flag_n) else $error("no reload after zero");
   chk_sync_zero: assert property (quiet && !i_load_sync_n && i_preset_bus_bits == 8'h00
      ##1 quiet && !i_count_gate_n |-> !o_zero_flag_n) else $error("sync load of zero lost");
   chk_wait_state: assert property ($rose(i_penable) && i_psel |=> o_pready)
      else $error("ready not one cycle into access");
   chk_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready held");
   chk_idle_bus: assert property (!o_pready |-> o_prdata == 32'h0 && !o_pslverr)
      else $error("read data outside access");
endmodule : pdc_sva
bind presettable_down_counter pdc_sva u_pdc_sva (.*);

// ---- tb/upstream_stage.sv ----
`timescale 1ns/1ps
module upstream_stage (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_solid,
   input wire logic i_run,
   output logic o_zero_flag_n
);
   logic phase;
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) phase <= 1'b0;
      else phase <= i_run & ~phase;
   end
   // zero flag of a divide-by-two stage, chained into the next gate
   assign o_zero_flag_n = ~(i_solid | (i_run & phase));
endmodule : upstream_stage

// ---- tb/presettable_down_counter_tb.sv ----
`timescale 1ns/1ps
module presettable_down_counter_tb import down_counter_pkg::*;;
   logic clk = 0, rstn = 0, ls = 1, la = 1, sm = 1, solid = 0, run = 0, gate_n, flag_n;
   logic psel = 0, pen = 0, pwr = 0, rdy, serr;
   logic [7:0] pre = 8'h00;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0, prd;
   int err_total = 0, cmp_count = 0, cyc = 0;
   initial forever #50 clk = ~clk;
   upstream_stage u_upstream_stage (.i_ref_clk(clk), .i_rstn(rstn), .i_solid(solid),
      .i_run(run), .o_zero_flag_n(gate_n));
   presettable_down_counter u_presettable_down_counter (.i_ref_clk(clk), .i_rstn(rstn),
      .i_count_gate_n(gate_n), .i_load_sync_n(ls), .i_load_async_n(la), .i_set_max_n(sm),
      .i_preset_bus_bits(pre), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
      .i_pwdata(pwd), .o_pready(rdy), .o_prdata(prd), .o_pslverr(serr), .o_zero_flag_n(flag_n));
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] e, input logic x);
      @(posedge clk) {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, e};
      @(posedge clk) pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      if (!w) chk("read data", e, prd);
      chk("slave error", x, serr);
      {psel, pen} <= 2'b00;
   endtask : apb
   task automatic ctl(input logic [4:0] c, input logic [7:0] p);
      @(posedge clk) {ls, la, sm, solid, run, pre} <= {c, p};
   endtask : ctl
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      ctl(5'b01100, 8'h02);
      ctl(5'b11110, 8'h02);
      repeat (2) @(posedge clk);
      @(negedge clk) chk("zero flag", 1'b0, flag_n);
      chk("gated zero flag", 1'b0, flag_n | clk);
      ctl(5'b11100, 8'h02);
      repeat (5) @(posedge clk);
      apb(STATUS_OFFSET, 1'b0, {24'h0, MAX_BINARY}, 1'b0);
      $display("binary count test done");
      apb(CTRL_OFFSET, 1'b1, 32'h1, 1'b0);
      apb(CTRL_OFFSET, 1'b0, 32'h1, 1'b0);
      ctl(5'b01100, 8'h10);
      ctl(5'b11101, 8'h10);
      @(posedge clk);
      ctl(5'b11100, 8'h10);
      apb(STATUS_OFFSET, 1'b0, 32'h09, 1'b0);
      ctl(5'b10000, 8'h42);
      apb(STATUS_OFFSET, 1'b0, {24'h0, MAX_DECIMAL}, 1'b0);
      ctl(5'b10100, 8'h42);
      apb(STATUS_OFFSET, 1'b0, 32'h42, 1'b0);
      ctl(5'b10110, 8'h00);
      @(negedge clk) chk("zero flag", 1'b0, flag_n);
      apb(STATUS_OFFSET, 1'b0, 32'h100, 1'b0);
      ctl(5'b01110, 8'h00);
      ctl(5'b11110, 8'h00);
      ctl(5'b11100, 8'h00);
      apb(STATUS_OFFSET, 1'b0, {24'h0, MAX_DECIMAL}, 1'b0);
      apb(12'h008, 1'b0, 32'h0, 1'b1);
      $display("decimal and preset test done");
      close_out();
   end
endmodule : presettable_down_counter_tb
